// >>> hw/rbw_block_write.sv
`timescale 1ns/100ps
// Function
// - Command code 0x08 starts a write; data is stored into nonvolatile memory.
// - Service count must be 1 to 11, otherwise error response.
// - Block count 1..12 with up to 8 services, 1..11 with 9..11.
// - All listed service identifiers must be equal, otherwise error.
// - Identifier value itself is never interpreted beyond equality.
// - Reply is 0x09, 8-byte card id, status flag 1, status flag 2.
// - In tunnel mode write data goes to the host, not to memory.
// - Password check uses one block, list 0x000001, 16 bytes; other counts error.
// - Password state restricts what later write commands may do.
// - NDEF exchange needs no dedicated command, only memory contents.
// - Block 0 at address 0x0000 is the attribute information block.
// - NDEF file occupies blocks 1 to 59, addresses 0x0010 to 0x03B0.
module rbw_block_write
    import rbw_pkg::*;
(
    input  wire logic                MCLK_IN,
    input  wire logic                RESETN_IN,
    input  wire logic                RX_VALID_IN,
    input  wire logic [7:0]          RX_DATA_IN,
    input  wire logic                RX_LAST_IN,
    output logic                     RX_READY_OUT,
    output logic                     TX_VALID_OUT,
    output logic [7:0]               TX_DATA_OUT,
    output logic                     TX_LAST_OUT,
    input  wire logic                TX_READY_IN,
    output logic                     MEM_WE_OUT,
    output logic [ADDR_W-1:0]        MEM_ADDR_OUT,
    output logic [127:0]             MEM_DATA_OUT,
    output logic                     MEM_ATTR_OUT,
    output logic                     TUN_VALID_OUT,
    output logic [7:0]               TUN_DATA_OUT,
    input  wire logic                TUN_READY_IN,
    input  wire logic                PROTECT_EN_IN,
    input  wire logic [127:0]        PASSWORD_IN,
    output logic                     VERIFIED_OUT
);
    typedef struct packed {
        rbw_phase_t                     ph;
        logic [63:0]                    idm;
        logic [7:0]                     k;
        logic [7:0]                     m;
        logic [7:0]                     cnt;
        logic [15:0]                    sfid;
        logic [7:0]                     sfid_lo;
        logic [7:0]                     err;
        logic [1:0]                     eb;
        logic [7:0]                     ehead;
        logic [7:0]                     ebyte1;
        logic [3:0]                     bi;
        logic [3:0]                     db;
        logic [M_SLOTS-1:0][BLK_W-1:0]  blks;
        logic                           tunnel;
        logic                           verify;
        logic                           verified;
        logic                           foreign;
        logic [127:0]                   dbuf;
        logic                           mem_we;
        logic [ADDR_W-1:0]              mem_addr;
        logic                           mem_attr;
        logic                           tun_valid;
        logic [7:0]                     tun_data;
        logic [3:0]                     tx_idx;
        logic [7:0]                     tx_byte;
    } rbw_state_t;

    localparam rbw_state_t RST_STATE = '0;

    rbw_state_t st;
    rbw_state_t next_st;
    rbw_chk_if  chk_bus ();

    logic       take;
    logic [7:0] b;
    logic [15:0] blk_no;
    logic [127:0] full_blk;

    // keeps the first error only, so the reply names the earliest fault
    function automatic logic [7:0] keep_err(input logic [7:0] cur, input logic [7:0] code);
        keep_err = (cur == SF_OK) ? code : cur;
    endfunction

    // reply byte at a given position
    function automatic logic [7:0] resp_byte(input rbw_state_t s, input logic [3:0] idx);
        if (idx == 4'h0) begin
            resp_byte = RESP_CODE;
        end else if (idx <= IDM_BYTES) begin
            resp_byte = s.idm[63 - 8*(idx - 4'h1) -: 8];
        end else if (idx == IDM_BYTES + 4'h1) begin
            resp_byte = (s.err == SF_OK) ? SF_OK : SF1_ERR;
        end else begin
            resp_byte = s.err;
        end
    endfunction

    rbw_range_check u_check (
        .chk (chk_bus.chk)
    );

    assign chk_bus.k = st.k;
    assign chk_bus.m = RX_DATA_IN;

    // a held tunnel byte stalls the receive side until the host takes it
    assign RX_READY_OUT  = (st.ph != RBW_RESP) && !(st.tun_valid && !TUN_READY_IN);
    assign take          = RX_VALID_IN && RX_READY_OUT;
    assign b             = RX_DATA_IN;
    assign blk_no        = st.ehead[ELEM_SHORT_BIT] ? {8'h00, b} : {b, st.ebyte1};
    assign full_blk      = {st.dbuf[119:0], b};

    assign TX_VALID_OUT  = (st.ph == RBW_RESP);
    assign TX_DATA_OUT   = st.tx_byte;
    assign TX_LAST_OUT   = (st.ph == RBW_RESP) && (st.tx_idx == RESP_LAST_IDX);
    assign MEM_WE_OUT    = st.mem_we;
    assign MEM_ADDR_OUT  = st.mem_addr;
    assign MEM_DATA_OUT  = st.dbuf;
    assign MEM_ATTR_OUT  = st.mem_attr;
    assign TUN_VALID_OUT = st.tun_valid;
    assign TUN_DATA_OUT  = st.tun_data;
    assign VERIFIED_OUT  = st.verified;

    // command parser; NDEF needs no command of its own, it lives in plain blocks
    always_comb begin
        next_st        = st;
        next_st.mem_we = 1'b0;
        if (st.tun_valid && TUN_READY_IN) begin
            next_st.tun_valid = 1'b0;
        end
        if (take) begin
            next_st.cnt = st.cnt + 8'h01;
            case (st.ph)
                RBW_CODE: begin
                    next_st     = RST_STATE;
                    next_st.verified = st.verified;
                    // a zero service count is still our frame, so it must not look foreign
                    next_st.foreign  = (b != CMD_WRITE);
                    next_st.ph  = (b == CMD_WRITE) ? RBW_IDM : RBW_SKIP;
                end
                RBW_IDM: begin
                    next_st.idm = {st.idm[55:0], b};
                    if (st.cnt == 8'(IDM_BYTES - 4'h1)) begin
                        next_st.ph = RBW_K;
                    end
                end
                RBW_K: begin
                    next_st.k   = b;
                    next_st.cnt = 8'h00;
                    next_st.ph  = RBW_SFID;
                end
                RBW_SFID: begin
                    // values are only compared, never decoded
                    if (!st.cnt[0]) begin
                        next_st.sfid_lo = b;
                    end else if (st.cnt == 8'h01) begin
                        next_st.sfid = {b, st.sfid_lo};
                    end else if ({b, st.sfid_lo} != st.sfid) begin
                        next_st.err = keep_err(next_st.err, ERR_SFID);
                    end
                    if (st.cnt + 8'h01 >= {st.k[6:0], 1'b0}) begin
                        next_st.ph = RBW_M;
                    end
                end
                RBW_M: begin
                    if (!chk_bus.k_ok) begin
                        next_st.err = keep_err(next_st.err, ERR_K);
                    end else if (!chk_bus.m_ok) begin
                        next_st.err = keep_err(next_st.err, ERR_M);
                    end
                    next_st.m  = b;
                    next_st.bi = 4'h0;
                    next_st.eb = 2'd0;
                    // a bad count leaves the rest of the frame unparsable
                    next_st.ph = (chk_bus.k_ok && chk_bus.m_ok) ? RBW_LIST : RBW_SKIP;
                end
                RBW_LIST: begin
                    next_st.eb = st.eb + 2'd1;
                    if (st.eb == 2'd0) begin
                        next_st.ehead = b;
                        if (b[ELEM_TUN_BIT]) begin
                            next_st.tunnel = 1'b1;
                        end
                    end else if (st.eb == 2'd1 && !st.ehead[ELEM_SHORT_BIT]) begin
                        next_st.ebyte1 = b;
                    end else begin
                        next_st.eb = 2'd0;
                        next_st.bi = st.bi + 4'h1;
                        if ({st.ehead, st.ebyte1, b} == VERIFY_LIST && st.bi == 4'h0) begin
                            next_st.verify = 1'b1;
                            if (st.m != VERIFY_M) begin
                                next_st.err = keep_err(next_st.err, ERR_M);
                            end
                        end else if (blk_no >= SYS_FIRST && !next_st.tunnel) begin
                            next_st.err = keep_err(next_st.err, ERR_BLOCK);
                        end else if (PROTECT_EN_IN && !st.verified) begin
                            next_st.err = keep_err(next_st.err, ERR_AUTH);
                        end
                        next_st.blks[st.bi] = blk_no[BLK_W-1:0];
                        if (st.bi + 4'h1 == st.m[3:0]) begin
                            next_st.ph = RBW_DATA;
                            next_st.bi = 4'h0;
                            next_st.db = 4'h0;
                        end
                    end
                end
                RBW_DATA: begin
                    next_st.dbuf = full_blk;
                    next_st.db   = st.db + 4'h1;
                    if (st.tunnel && !st.verify && st.err == SF_OK) begin
                        next_st.tun_valid = 1'b1;
                        next_st.tun_data  = b;
                    end
                    if (st.db == BLOCK_LAST_BYTE) begin
                        next_st.bi = st.bi + 4'h1;
                        if (st.verify) begin
                            next_st.verified = (full_blk == PASSWORD_IN);
                            if (full_blk != PASSWORD_IN) begin
                                next_st.err = keep_err(next_st.err, ERR_AUTH);
                            end
                        end else if (!st.tunnel && st.err == SF_OK) begin
                            // direct write only after every count, identifier, block and password check passed; the length check comes later
                            next_st.mem_we   = 1'b1;
                            next_st.mem_addr = {st.blks[st.bi], 4'h0};
                            next_st.mem_attr = ({10'h000, st.blks[st.bi]} == ATTR_BLOCK);
                        end
                        if (st.bi + 4'h1 == st.m[3:0]) begin
                            next_st.ph = RBW_SKIP;
                        end
                    end
                end
                RBW_SKIP: begin
                    // bytes past the declared data are a length fault
                    if (st.m != 8'h00 && st.bi == st.m[3:0]) begin
                        next_st.err = keep_err(next_st.err, ERR_LEN);
                    end
                end
                default: begin
                    next_st.ph = st.ph;
                end
            endcase
            if (RX_LAST_IN) begin
                if (st.ph == RBW_CODE || (st.ph == RBW_SKIP && st.foreign)) begin
                    next_st.ph = RBW_CODE;                               // not ours: no reply
                end else begin
                    if (next_st.ph != RBW_SKIP) begin
                        next_st.err = keep_err(next_st.err, ERR_LEN);
                    end
                    next_st.ph      = RBW_RESP;
                    next_st.tx_idx  = 4'h0;
                    next_st.tx_byte = RESP_CODE;
                end
            end
        end
        // reply stream
        if (st.ph == RBW_RESP && TX_READY_IN) begin
            if (st.tx_idx == RESP_LAST_IDX) begin
                next_st.ph  = RBW_CODE;
                next_st.cnt = 8'h00;
            end else begin
                next_st.tx_idx  = st.tx_idx + 4'h1;
                next_st.tx_byte = resp_byte(st, st.tx_idx + 4'h1);
            end
        end
    end

    // single state register
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> hw/rbw_pkg.sv
package rbw_pkg;
    // command and response framing
    localparam logic [7:0]  CMD_WRITE      = 8'h08;
    localparam logic [7:0]  RESP_CODE      = 8'h09;
    localparam logic [3:0]  IDM_BYTES      = 4'h8;
    localparam logic [3:0]  RESP_LAST_IDX  = 4'ha;   // code + 8 id bytes + 2 flags
    localparam logic [3:0]  BLOCK_LAST_BYTE = 4'hf;  // 16 bytes per block
    // service and block count ranges
    localparam logic [7:0]  K_MIN          = 8'h01;
    localparam logic [7:0]  K_MAX          = 8'h0b;
    localparam logic [7:0]  K_SPLIT        = 8'h08;
    localparam logic [7:0]  M_MIN          = 8'h01;
    localparam logic [7:0]  M_MAX_FEW      = 8'h0c;
    localparam logic [7:0]  M_MAX_MANY     = 8'h0b;
    localparam int          M_SLOTS        = 12;
    // password check
    localparam logic [23:0] VERIFY_LIST    = 24'h000001;
    localparam logic [7:0]  VERIFY_M       = 8'h01;
    // block list element head: bit 7 picks the short form, bit 4 the host path
    localparam int          ELEM_SHORT_BIT = 7;
    localparam int          ELEM_TUN_BIT   = 4;
    // memory map in blocks
    localparam logic [15:0] ATTR_BLOCK     = 16'h0000;
    localparam logic [15:0] NDEF_LAST      = 16'h003b;
    localparam logic [15:0] SYS_FIRST      = 16'h003c;
    localparam int          BLK_W          = 6;
    localparam int          ADDR_W         = 10;
    // status flags
    localparam logic [7:0]  SF_OK          = 8'h00;
    localparam logic [7:0]  SF1_ERR        = 8'hff;
    localparam logic [7:0]  ERR_K          = 8'ha1;
    localparam logic [7:0]  ERR_M          = 8'ha2;
    localparam logic [7:0]  ERR_SFID       = 8'ha3;
    localparam logic [7:0]  ERR_BLOCK      = 8'ha4;
    localparam logic [7:0]  ERR_AUTH       = 8'ha5;
    localparam logic [7:0]  ERR_LEN        = 8'ha6;

    typedef enum logic [3:0] {
        RBW_CODE, RBW_IDM, RBW_K, RBW_SFID, RBW_M, RBW_LIST, RBW_DATA, RBW_SKIP, RBW_RESP
    } rbw_phase_t;
endpackage

// >>> hw/rbw_chk_if.sv
`timescale 1ns/100ps
interface rbw_chk_if;
    logic [7:0] k;
    logic [7:0] m;
    logic       k_ok;
    logic       m_ok;
    modport chk  (input k, input m, output k_ok, output m_ok);
    modport user (output k, output m, input k_ok, input m_ok);
endinterface

// >>> hw/rbw_range_check.sv
`timescale 1ns/100ps
module rbw_range_check
    import rbw_pkg::*;
(
    rbw_chk_if.chk chk
);
    // service count window and block count window that narrows with many services
    always_comb begin
        chk.k_ok = (chk.k >= K_MIN) && (chk.k <= K_MAX);
        if (chk.k <= K_SPLIT) begin
            chk.m_ok = (chk.m >= M_MIN) && (chk.m <= M_MAX_FEW);
        end else begin
            chk.m_ok = (chk.m >= M_MIN) && (chk.m <= M_MAX_MANY);
        end
    end
endmodule

// >>> dv/rbw_host_model.sv
`timescale 1ns/100ps
module rbw_host_model (
    input  wire logic       MCLK_IN,
    input  wire logic       SLOW_IN,
    input  wire logic       TX_VALID_IN,
    input  wire logic [7:0] TX_DATA_IN,
    input  wire logic       TUN_VALID_IN,
    input  wire logic [7:0] TUN_DATA_IN,
    output logic            TX_READY_OUT,
    output logic            TUN_READY_OUT
);
    logic [7:0] reply_q[$];
    logic [7:0] tun_q[$];
    logic [1:0] phase = 2'h0;
    // collect bytes at the edge where both sides agree
    always @(posedge MCLK_IN) begin
        if (TX_VALID_IN && TX_READY_OUT) reply_q.push_back(TX_DATA_IN);
        if (TUN_VALID_IN && TUN_READY_OUT) tun_q.push_back(TUN_DATA_IN);
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        // slow partner takes one cycle in three, so holding logic gets exercised
        TX_READY_OUT <= !SLOW_IN || (phase == 2'h2);
        TUN_READY_OUT <= !SLOW_IN || (phase == 2'h1);
    end
endmodule

// >>> dv/rbw_block_write_monitor.sv
`timescale 1ns/100ps
module rbw_block_write_monitor
    import rbw_pkg::*;
(
    input wire logic              MCLK_IN,
    input wire logic              RESETN_IN,
    input wire logic              RX_READY_OUT,
    input wire logic              TX_VALID_OUT,
    input wire logic [7:0]        TX_DATA_OUT,
    input wire logic              TX_LAST_OUT,
    input wire logic              TX_READY_IN,
    input wire logic              MEM_WE_OUT,
    input wire logic [ADDR_W-1:0] MEM_ADDR_OUT,
    input wire logic              MEM_ATTR_OUT,
    input wire logic              TUN_VALID_OUT,
    input wire logic [7:0]        TUN_DATA_OUT,
    input wire logic              TUN_READY_IN
);
    logic [3:0] sent;
    // accepted reply bytes; restarts after the closing byte
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN || (TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT)) sent <= 4'h0;
        else if (TX_VALID_OUT && TX_READY_IN) sent <= sent + 4'h1;
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence tx_wait; TX_VALID_OUT && !TX_READY_IN; endsequence
    sequence tx_end; TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT; endsequence
    chk_reply_code: assert property ($rose(TX_VALID_OUT) |-> TX_DATA_OUT == RESP_CODE)
        else $error("reply opens with a wrong code");
    chk_reply_len: assert property (TX_VALID_OUT && TX_LAST_OUT |-> sent == 4'ha)
        else $error("reply length wrong");
    chk_reply_hold: assert property (tx_wait |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
        else $error("reply byte dropped while stalled");
    chk_reply_done: assert property (tx_end |=> !TX_VALID_OUT)
        else $error("reply runs past its last byte");
    chk_rx_blocked: assert property (TX_VALID_OUT |-> !RX_READY_OUT)
        else $error("command bytes taken during reply");
    chk_we_pulse: assert property (MEM_WE_OUT |=> !MEM_WE_OUT)
        else $error("memory strobe longer than one cycle");
    chk_attr_flag: assert property (MEM_WE_OUT |-> MEM_ATTR_OUT == (MEM_ADDR_OUT == 10'h000))
        else $error("attribute flag wrong");
    chk_sys_guard: assert property (MEM_WE_OUT |-> MEM_ADDR_OUT <= 10'h3b0)
        else $error("write reached the system area");
    chk_tun_hold: assert property (TUN_VALID_OUT && !TUN_READY_IN |=>
        TUN_VALID_OUT && $stable(TUN_DATA_OUT))
        else $error("host byte dropped while stalled");
    chk_tun_nomem: assert property (TUN_VALID_OUT |-> !MEM_WE_OUT)
        else $error("memory written during host transfer");
endmodule
bind rbw_block_write rbw_block_write_monitor i_rbw_block_write_monitor (.MCLK_IN, .RESETN_IN,
    .RX_READY_OUT, .TX_VALID_OUT, .TX_DATA_OUT, .TX_LAST_OUT, .TX_READY_IN, .MEM_WE_OUT,
    .MEM_ADDR_OUT, .MEM_ATTR_OUT, .TUN_VALID_OUT, .TUN_DATA_OUT, .TUN_READY_IN);

// >>> dv/rbw_block_write_bench.sv
`timescale 1ns/100ps
module rbw_block_write_bench;
    import rbw_pkg::*;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              rx_valid = 1'b0;
    logic [7:0]        rx_data = 8'h00;
    logic              rx_last = 1'b0;
    logic              protect = 1'b0;
    logic              slow = 1'b0;
    logic              rx_ready, tx_valid, tx_last, tx_ready, mem_we, mem_attr;
    logic              tun_valid, tun_ready, verified;
    logic [7:0]        tx_data, tun_data;
    logic [ADDR_W-1:0] mem_addr;
    logic [127:0]      mem_data;
    logic [138:0]      mem_q[$];
    int                errors = 0;
    int                checks = 0;
    rbw_block_write i_rbw_block_write (.MCLK_IN(mclk), .RESETN_IN(rst_n), .RX_VALID_IN(rx_valid),
        .RX_DATA_IN(rx_data), .RX_LAST_IN(rx_last), .RX_READY_OUT(rx_ready),
        .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last),
        .TX_READY_IN(tx_ready), .MEM_WE_OUT(mem_we), .MEM_ADDR_OUT(mem_addr),
        .MEM_DATA_OUT(mem_data), .MEM_ATTR_OUT(mem_attr), .TUN_VALID_OUT(tun_valid),
        .TUN_DATA_OUT(tun_data), .TUN_READY_IN(tun_ready), .PROTECT_EN_IN(protect),
        .PASSWORD_IN(128'h404142434445464748494a4b4c4d4e4f), .VERIFIED_OUT(verified));
    rbw_host_model i_rbw_host_model (.MCLK_IN(mclk), .SLOW_IN(slow), .TX_VALID_IN(tx_valid),
        .TX_DATA_IN(tx_data), .TUN_VALID_IN(tun_valid), .TUN_DATA_IN(tun_data),
        .TX_READY_OUT(tx_ready), .TUN_READY_OUT(tun_ready));
    // clock and memory write log
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) if (mem_we === 1'b1) mem_q.push_back({mem_attr, mem_addr, mem_data});
    task automatic check(input logic [138:0] seen, input logic [138:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] pat(logic [7:0] base, int i, int j);
        return base + 8'(i * 16 + j);
    endfunction
    function automatic logic [138:0] blk_exp(int b, logic [7:0] base, int i);
        logic [127:0] d;
        for (int j = 0; j < 16; j++) d = {d[119:0], pat(base, i, j)};
        return {(b == 0), 10'(b * 16), d};
    endfunction
    // code, id, two flags; flag 1 marks any failure
    function automatic logic [7:0] rsp(int i, logic [7:0] sf2);
        if (i == 0) return RESP_CODE;
        if (i < 9) return 8'he0 + 8'(i - 1);
        if (i == 9) return (sf2 == SF_OK) ? SF_OK : SF1_ERR;
        return sf2;
    endfunction
    // offer each byte until the design takes it, last one flagged
    task automatic send(input logic [7:0] q[$]);
        logic ok;
        for (int i = 0; i < q.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_last <= (i == q.size() - 1);
            do begin
                @(negedge mclk);
                ok = rx_ready;
                @(posedge mclk);
            end while (ok !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
    // build one frame, send it, then judge reply, memory and host traffic
    task automatic run(input int k, input bit diff, input int m, input int blk, input bit tun,
                       input bit pw, input logic [7:0] base, input logic [7:0] sf2);
        logic [7:0] q[$];
        int         n;
        mem_q.delete();
        i_rbw_host_model.reply_q.delete();
        i_rbw_host_model.tun_q.delete();
        q.push_back(CMD_WRITE);
        for (int i = 0; i < 8; i++) q.push_back(8'he0 + 8'(i));
        q.push_back(8'(k));
        for (int i = 0; i < k; i++) q = {q, 8'h00, (diff && i == k - 1) ? 8'h0a : 8'h09};
        q.push_back(8'(m));
        for (int i = 0; i < m; i++) begin
            if (pw) q = {q, 8'h00, 8'h00, 8'h01};
            else q = {q, tun ? 8'h90 : 8'h80, 8'(blk + i)};
        end
        for (int i = 0; i < 16 * m; i++) q.push_back(pat(base, i / 16, i % 16));
        send(q);
        for (n = 0; n < 200 && i_rbw_host_model.reply_q.size() < 11; n++) @(posedge mclk);
        @(negedge mclk);
        check(i_rbw_host_model.reply_q.size(), 11);
        for (int i = 0; i < 11; i++) check(i_rbw_host_model.reply_q[i], rsp(i, sf2));
        n = (sf2 == SF_OK && !tun && !pw) ? m : 0;
        check(mem_q.size(), n);
        for (int i = 0; i < n; i++) check(mem_q[i], blk_exp(blk + i, base, i));
        n = (sf2 == SF_OK && tun) ? 16 * m : 0;
        check(i_rbw_host_model.tun_q.size(), n);
        for (int i = 0; i < n; i++) check(i_rbw_host_model.tun_q[i], pat(base, i / 16, i % 16));
        @(posedge mclk);
    endtask
    // direct write of one block
    task automatic t_plain;
        run(1, 0, 1, 5, 0, 0, 8'h20, SF_OK);
    endtask
    // service and block count edges, slow reply sink on the widest frame
    task automatic t_ranges;
        run(0, 0, 1, 1, 0, 0, 8'h00, ERR_K);
        run(12, 0, 1, 1, 0, 0, 8'h00, ERR_K);
        run(11, 0, 12, 1, 0, 0, 8'h00, ERR_M);
        run(9, 0, 11, 1, 0, 0, 8'h10, SF_OK);
        run(1, 0, 0, 1, 0, 0, 8'h00, ERR_M);
        slow <= 1'b1;
        run(8, 0, 12, 0, 0, 0, 8'h70, SF_OK);
        slow <= 1'b0;
    endtask
    // identifier mismatch and memory map bounds
    task automatic t_map;
        run(3, 1, 1, 7, 0, 0, 8'h30, ERR_SFID);
        run(1, 0, 1, 60, 0, 0, 8'h30, ERR_BLOCK);
        run(1, 0, 1, 59, 0, 0, 8'h38, SF_OK);
    endtask
    // attribute block with its checksum, then a system code aimed at the system area
    task automatic t_attr;
        logic [7:0]   q[$];
        logic [127:0] d;
        for (int w = 0; w < 2; w++) begin
            mem_q.delete();
            i_rbw_host_model.reply_q.delete();
            d = (w == 0) ? 128'h100f0b00180000000000010000030000 : {16'h12fc, 112'h0};
            if (w == 0) begin
                for (int j = 0; j < 14; j++) d[15:0] += 16'(d[127 - 8 * j -: 8]);
            end
            q = {CMD_WRITE};
            for (int i = 0; i < 8; i++) q.push_back(8'he0 + 8'(i));
            q = {q, 8'h01, 8'h00, 8'h09, 8'h01, 8'h80, (w == 0) ? 8'h00 : 8'h3e};
            for (int j = 0; j < 16; j++) q.push_back(d[127 - 8 * j -: 8]);
            send(q);
            for (int n = 0; n < 200 && i_rbw_host_model.reply_q.size() < 11; n++)
                @(posedge mclk);
            @(negedge mclk);
            check(i_rbw_host_model.reply_q[10], (w == 0) ? SF_OK : ERR_BLOCK);
            check(mem_q.size(), 1 - w);
            if (w == 0) check(mem_q[0], {1'b1, 10'h000, d});
            @(posedge mclk);
        end
    endtask
    // protection gate around the password check
    task automatic t_verify;
        protect <= 1'b1;
        run(1, 0, 1, 2, 0, 0, 8'h50, ERR_AUTH);
        run(1, 0, 1, 0, 0, 1, 8'h41, ERR_AUTH);
        check(verified, 1'b0);
        run(1, 0, 2, 0, 0, 1, 8'h40, ERR_M);
        run(1, 0, 1, 0, 0, 1, 8'h40, SF_OK);
        check(verified, 1'b1);
        run(1, 0, 1, 2, 0, 0, 8'h50, SF_OK);
        protect <= 1'b0;
    endtask
    // host path with a stalling host
    task automatic t_tunnel;
        slow <= 1'b1;
        run(1, 0, 2, 3, 1, 0, 8'h60, SF_OK);
        slow <= 1'b0;
    endtask
    // a frame with another command code is swallowed without a reply
    task automatic t_foreign;
        logic [7:0] q[$];
        i_rbw_host_model.reply_q.delete();
        q = {8'h06, 8'h08, 8'h09};
        send(q);
        repeat (20) @(posedge mclk);
        check(i_rbw_host_model.reply_q.size(), 0);
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog well beyond the roughly 1600 cycles the frames need
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_plain();
        t_ranges();
        t_map();
        t_attr();
        t_verify();
        t_tunnel();
        t_foreign();
        report_and_stop();
    end
endmodule
